// file: design/agpbr_map.svh
// register offsets, field positions, reset values and decode ranges of the bridge routing block
`ifndef AGPBR_MAP_SVH
`define AGPBR_MAP_SVH

// register offsets on the plain register port
`define AGPBR_BCTRL_OFS 8'h3E
`define AGPBR_IRQ_STAT_OFS 8'h80
`define AGPBR_IRQ_MASK_OFS 8'h81
`define AGPBR_ROUTE_STAT_OFS 8'h82

// bridge control fields
`define AGPBR_BCTRL_RST 8'h00
`define AGPBR_BCTRL_WMASK 8'h0D
`define AGPBR_BIT_PARITY_REPORT 0
`define AGPBR_BIT_RSVD_LOW 1
`define AGPBR_BIT_ALIAS_FILTER 2
`define AGPBR_BIT_VIDEO_ROUTE 3
`define AGPBR_BIT_RSVD_HIGH 4

// interrupt status and mask fields
`define AGPBR_IRQ_RST 8'h00
`define AGPBR_IRQ_WMASK 8'h07
`define AGPBR_IRQ_PARITY 0
`define AGPBR_IRQ_SERR_SENT 1
`define AGPBR_IRQ_VIDEO_HIT 2

// route status fields
`define AGPBR_RS_GRAPHICS 0
`define AGPBR_RS_VIDEO 1
`define AGPBR_RS_SERR_BUSY 2

// legacy video windows
`define AGPBR_VIDEO_MEM_LO 32'h000A0000
`define AGPBR_VIDEO_MEM_HI 32'h000BFFFF
`define AGPBR_VIDEO_IO0_LO 10'h3B0
`define AGPBR_VIDEO_IO0_HI 10'h3BB
`define AGPBR_VIDEO_IO1_LO 10'h3C0
`define AGPBR_VIDEO_IO1_HI 10'h3DF

// don't-care low bits of window limits
`define AGPBR_MEM_LIMIT_LOW 20'hFFFFF
`define AGPBR_IO_LIMIT_LOW 12'hFFF

`endif

// file: design/agpbr_pkg.sv
// types shared by the bridge routing block
package agpbr_pkg;

   typedef enum logic {
      AGPBR_TO_HUB,
      AGPBR_TO_GRAPHICS
   } agpbr_route_e;

   typedef enum logic {
      AGPBR_MSG_IDLE,
      AGPBR_MSG_SEND
   } agpbr_msg_state_e;

endpackage : agpbr_pkg

// file: design/agpbr_decode.sv
// combinational routing decision for one host transaction
`timescale 1ns/1ns
`include "agpbr_map.svh"

module agpbr_decode
   import agpbr_pkg::*;
(
   // control bits
   input wire logic video_route_i,
   input wire logic alias_filter_i,
   // windows
   input wire logic [3:0] io_window_base_i,
   input wire logic [3:0] io_window_limit_i,
   input wire logic [11:0] memory_window_base_i,
   input wire logic [11:0] memory_window_limit_i,
   input wire logic [11:0] prefetch_window_base_i,
   input wire logic [11:0] prefetch_window_limit_i,
   // transaction
   input wire logic req_io_i,
   input wire logic [31:0] addr_i,
   // decision
   output agpbr_route_e route_o,
   output logic video_hit_o
);

   // inclusive base..limit, limit low bits taken as all ones
   function automatic logic in_mem_window(input logic [31:0] a, input logic [11:0] b,
                                          input logic [11:0] l);
      in_mem_window = (a >= {b, 20'h00000}) && (a <= {l, `AGPBR_MEM_LIMIT_LOW});
   endfunction : in_mem_window

   logic legacy_mem;
   logic legacy_io;
   logic io_in_window;
   logic io_upper_alias;
   logic io_fwd;
   logic mem_fwd;

   always_comb
   begin
      legacy_mem = !req_io_i && (addr_i >= `AGPBR_VIDEO_MEM_LO) &&
                   (addr_i <= `AGPBR_VIDEO_MEM_HI);
      // bits 15:10 never looked at
      legacy_io = req_io_i &&
                  (((addr_i[9:0] >= `AGPBR_VIDEO_IO0_LO) && (addr_i[9:0] <= `AGPBR_VIDEO_IO0_HI)) ||
                   ((addr_i[9:0] >= `AGPBR_VIDEO_IO1_LO) &&
                    (addr_i[9:0] <= `AGPBR_VIDEO_IO1_HI)));
      io_in_window = req_io_i && (addr_i[15:0] >= {io_window_base_i, 12'h000}) &&
                     (addr_i[15:0] <= {io_window_limit_i, `AGPBR_IO_LIMIT_LOW});
      io_upper_alias = (addr_i[9:8] != 2'h0);
      // filter only narrows the window, never widens it
      io_fwd = io_in_window && !(alias_filter_i && io_upper_alias);
      mem_fwd = !req_io_i &&
                (in_mem_window(addr_i, memory_window_base_i, memory_window_limit_i) ||
                 in_mem_window(addr_i, prefetch_window_base_i, prefetch_window_limit_i));
      video_hit_o = video_route_i && (legacy_mem || legacy_io);
      // video hit overrides windows and filter
      if (video_hit_o || io_fwd || mem_fwd)
      begin
         route_o = AGPBR_TO_GRAPHICS;
      end
      else
      begin
         route_o = AGPBR_TO_HUB;
      end
   end

endmodule : agpbr_decode

// file: design/agpbr_serr_msg.sv
// system-error message sender toward the hub link
`timescale 1ns/1ns

module agpbr_serr_msg
   import agpbr_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // events
   input wire logic event_i,
   // hub link handshake
   output logic msg_req_o,
   input wire logic msg_ack_i,
   output logic sent_o
);

   agpbr_msg_state_e state;
   logic queued;

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         state <= AGPBR_MSG_IDLE;
      end
      else
      begin
         case (state)
            AGPBR_MSG_IDLE:
            begin
               if (event_i)
               begin
                  state <= AGPBR_MSG_SEND;
               end
            end
            AGPBR_MSG_SEND:
            begin
               if (msg_ack_i && !queued && !event_i)
               begin
                  state <= AGPBR_MSG_IDLE;
               end
            end
            default:
            begin
               state <= AGPBR_MSG_IDLE;
            end
         endcase
      end
   end

   // one further event held while a message is outstanding; clear wins over set
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         queued <= 1'b0;
      end
      else if (state == AGPBR_MSG_SEND)
      begin
         if (msg_ack_i)
         begin
            queued <= 1'b0;
         end
         else if (event_i)
         begin
            queued <= 1'b1;
         end
      end
      else
      begin
         queued <= 1'b0;
      end
   end

   assign msg_req_o = (state == AGPBR_MSG_SEND);
   assign sent_o = msg_req_o && msg_ack_i;

endmodule : agpbr_serr_msg

// file: design/agpbr_route_ctrl.sv
// bridge routing control: registers, host routing decision, error messaging, interrupt
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
`include "agpbr_map.svh"

module agpbr_route_ctrl
   import agpbr_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // window registers and system-error enable held elsewhere
   input wire logic [3:0] io_window_base_i,
   input wire logic [3:0] io_window_limit_i,
   input wire logic [11:0] memory_window_base_i,
   input wire logic [11:0] memory_window_limit_i,
   input wire logic [11:0] prefetch_window_base_i,
   input wire logic [11:0] prefetch_window_limit_i,
   input wire logic bridge_system_error_enable_i,
   // host transactions
   input wire logic host_req_i,
   input wire logic host_req_io_i,
   input wire logic [31:0] host_addr_i,
   output logic route_valid_o,
   output logic route_graphics_o,
   // graphics port error events
   input wire logic agp_addr_parity_err_i,
   input wire logic agp_data_parity_err_i,
   input wire logic other_serr_event_i,
   // hub link message handshake
   output logic serr_msg_req_o,
   input wire logic serr_msg_ack_i,
   // interrupt
   output logic irq_o
);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // register decode

   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
      addr_hit = (a == ofs);
   endfunction : addr_hit

   logic [7:0] bridge_control;
   logic [7:0] irq_status;
   logic [7:0] irq_mask;
   logic [7:0] route_status;
   logic legacy_video_route_enable;
   logic io_alias_filter_enable;
   logic parity_report_enable;

   logic wr_bctrl;
   logic wr_mask;
   logic rd_status;

   assign wr_bctrl = reg_wr_i && addr_hit(reg_addr_i, `AGPBR_BCTRL_OFS);
   assign wr_mask = reg_wr_i && addr_hit(reg_addr_i, `AGPBR_IRQ_MASK_OFS);
   assign rd_status = reg_rd_i && addr_hit(reg_addr_i, `AGPBR_IRQ_STAT_OFS);

   assign legacy_video_route_enable = bridge_control[`AGPBR_BIT_VIDEO_ROUTE];
   assign io_alias_filter_enable = bridge_control[`AGPBR_BIT_ALIAS_FILTER];
   assign parity_report_enable = bridge_control[`AGPBR_BIT_PARITY_REPORT];

   ////////////////////////////////////////////////////////////////////////////////////////////
   // bridge control and interrupt mask registers

   // only writable bits stored; reserved and hardwired bits stay zero
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         bridge_control <= `AGPBR_BCTRL_RST;
      end
      else if (wr_bctrl)
      begin
         bridge_control <= reg_wdata_i & `AGPBR_BCTRL_WMASK;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         irq_mask <= `AGPBR_IRQ_RST;
      end
      else if (wr_mask)
      begin
         irq_mask <= reg_wdata_i & `AGPBR_IRQ_WMASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // host routing decision

   agpbr_route_e route_now;
   logic video_hit_now;

   agpbr_decode u_decode (
      .video_route_i(legacy_video_route_enable),
      .alias_filter_i(io_alias_filter_enable),
      .io_window_base_i(io_window_base_i),
      .io_window_limit_i(io_window_limit_i),
      .memory_window_base_i(memory_window_base_i),
      .memory_window_limit_i(memory_window_limit_i),
      .prefetch_window_base_i(prefetch_window_base_i),
      .prefetch_window_limit_i(prefetch_window_limit_i),
      .req_io_i(host_req_io_i),
      .addr_i(host_addr_i),
      .route_o(route_now),
      .video_hit_o(video_hit_now)
   );

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         route_valid_o <= 1'b0;
      end
      else
      begin
         route_valid_o <= host_req_i;
      end
   end

   // decision held until the next request
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         route_graphics_o <= 1'b0;
      end
      else if (host_req_i)
      begin
         route_graphics_o <= (route_now == AGPBR_TO_GRAPHICS);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // system-error messaging

   // no parity error pin: errors leave as hub messages and as the parity interrupt status bit
   logic parity_err;
   logic parity_report;
   logic serr_event;
   logic serr_sent;

   assign parity_err = agp_addr_parity_err_i || agp_data_parity_err_i;
   assign parity_report = parity_err && parity_report_enable &&
                          bridge_system_error_enable_i;
   assign serr_event = parity_report || other_serr_event_i;

   agpbr_serr_msg u_serr (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .event_i(serr_event),
      .msg_req_o(serr_msg_req_o),
      .msg_ack_i(serr_msg_ack_i),
      .sent_o(serr_sent)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////
   // interrupt status, route status, read data

   logic [7:0] irq_set;

   always_comb
   begin
      irq_set = 8'h00;
      irq_set[`AGPBR_IRQ_PARITY] = parity_err;
      irq_set[`AGPBR_IRQ_SERR_SENT] = serr_sent;
      irq_set[`AGPBR_IRQ_VIDEO_HIT] = host_req_i && video_hit_now;
   end

   // read clears, a new event in the same cycle survives
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         irq_status <= `AGPBR_IRQ_RST;
      end
      else if (rd_status)
      begin
         irq_status <= irq_set;
      end
      else
      begin
         irq_status <= irq_status | irq_set;
      end
   end

   assign irq_o = |(irq_status & irq_mask);

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         route_status <= 8'h00;
      end
      else
      begin
         route_status[`AGPBR_RS_SERR_BUSY] <= serr_msg_req_o;
         if (host_req_i)
         begin
            route_status[`AGPBR_RS_GRAPHICS] <= (route_now == AGPBR_TO_GRAPHICS);
            route_status[`AGPBR_RS_VIDEO] <= video_hit_now;
         end
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         reg_rdata_o <= 8'h00;
      end
      else if (reg_rd_i)
      begin
         case (reg_addr_i)
            `AGPBR_BCTRL_OFS: reg_rdata_o <= bridge_control & `AGPBR_BCTRL_WMASK;
            `AGPBR_IRQ_STAT_OFS: reg_rdata_o <= irq_status;
            `AGPBR_IRQ_MASK_OFS: reg_rdata_o <= irq_mask;
            `AGPBR_ROUTE_STAT_OFS: reg_rdata_o <= route_status;
            default: reg_rdata_o <= 8'h00;
         endcase
      end
      else
      begin
         reg_rdata_o <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // checks

   AST_VIDEO_MEM: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      host_req_i && !host_req_io_i && legacy_video_route_enable &&
      (host_addr_i >= `AGPBR_VIDEO_MEM_LO) && (host_addr_i <= `AGPBR_VIDEO_MEM_HI)
      |=> route_valid_o && route_graphics_o)
      else $error("video memory access not sent to graphics");

   AST_VIDEO_IO: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      host_req_i && host_req_io_i && legacy_video_route_enable &&
      (host_addr_i[9:0] >= `AGPBR_VIDEO_IO1_LO) && (host_addr_i[9:0] <= `AGPBR_VIDEO_IO1_HI)
      |=> route_graphics_o)
      else $error("video io access not sent to graphics");

   AST_VIDEO_IO_ALIAS: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      host_req_i && host_req_io_i && legacy_video_route_enable &&
      (host_addr_i[15:10] != 6'h00) && (host_addr_i[9:0] >= `AGPBR_VIDEO_IO0_LO) &&
      (host_addr_i[9:0] <= `AGPBR_VIDEO_IO0_HI)
      |=> route_graphics_o)
      else $error("video io alias not forwarded");

   AST_VIDEO_OVER_WINDOWS: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      host_req_i && host_req_io_i && legacy_video_route_enable &&
      (io_window_base_i > io_window_limit_i) && (host_addr_i[9:0] == `AGPBR_VIDEO_IO0_LO)
      |=> route_graphics_o)
      else $error("video io lost with empty io window");

   AST_VIDEO_OVER_FILTER: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      host_req_i && host_req_io_i && legacy_video_route_enable && io_alias_filter_enable &&
      (host_addr_i[9:0] == `AGPBR_VIDEO_IO1_LO)
      |=> route_graphics_o)
      else $error("alias filter blocked video io");

   AST_VIDEO_OFF: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      host_req_i && !host_req_io_i && !legacy_video_route_enable &&
      (host_addr_i[31:20] == 12'h000) && (memory_window_base_i != 12'h000) &&
      (prefetch_window_base_i != 12'h000)
      |=> !route_graphics_o)
      else $error("unclaimed low memory sent to graphics");

   AST_IO_OUTSIDE: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      host_req_i && host_req_io_i && !legacy_video_route_enable &&
      (host_addr_i[15:12] > io_window_limit_i)
      |=> !route_graphics_o)
      else $error("io outside window sent to graphics");

   AST_ALIAS_FILTER: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      host_req_i && host_req_io_i && !legacy_video_route_enable && io_alias_filter_enable &&
      (host_addr_i[9:8] != 2'h0)
      |=> !route_graphics_o)
      else $error("filtered io alias sent to graphics");

   AST_FILTER_OFF: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      host_req_i && host_req_io_i && !io_alias_filter_enable &&
      (host_addr_i[15:12] >= io_window_base_i) && (host_addr_i[15:12] <= io_window_limit_i)
      |=> route_graphics_o)
      else $error("io inside window not sent to graphics");

   AST_MEM_LIMIT: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      host_req_i && !host_req_io_i && (host_addr_i[31:20] == memory_window_limit_i) &&
      (memory_window_base_i <= memory_window_limit_i)
      |=> route_graphics_o)
      else $error("top megabyte of memory window missed");

   AST_PARITY_MSG: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      !serr_msg_req_o && parity_err && parity_report_enable && bridge_system_error_enable_i
      |=> serr_msg_req_o)
      else $error("parity error produced no message");

   AST_PARITY_QUIET: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      !serr_msg_req_o && !parity_report_enable && !other_serr_event_i
      |=> !serr_msg_req_o)
      else $error("message sent with parity reporting off");

   AST_OTHER_MSG: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      !serr_msg_req_o && other_serr_event_i |=> serr_msg_req_o)
      else $error("other error produced no message");

   AST_RSVD_ZERO: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      reg_rd_i && addr_hit(reg_addr_i, `AGPBR_BCTRL_OFS)
      |=> (reg_rdata_o[`AGPBR_BIT_RSVD_HIGH] == 1'b0) && (reg_rdata_o[`AGPBR_BIT_RSVD_LOW] == 1'b0))
      else $error("reserved control bit read as one");

endmodule : agpbr_route_ctrl

// file: tb/agpbr_hub_model.sv
// hub link stand-in that accepts system-error messages after a set delay
`timescale 1ns/1ns

module agpbr_hub_model
(
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // message handshake
   input wire logic msg_req_i,
   output logic msg_ack_o,
   // control and tally
   input wire logic [3:0] delay_i,
   output int accepted_o
);
   logic [3:0] wait_cnt;

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         msg_ack_o <= 1'b0;
         wait_cnt <= 4'h0;
         accepted_o <= 0;
      end
      else
      begin
         msg_ack_o <= 1'b0;
         if (msg_ack_o && msg_req_i)
            accepted_o <= accepted_o + 1;
         // a request still up after an ack is a further message
         if (msg_req_i && !msg_ack_o)
         begin
            if (wait_cnt >= delay_i)
            begin
               msg_ack_o <= 1'b1;
               wait_cnt <= 4'h0;
            end
            else
               wait_cnt <= wait_cnt + 4'h1;
         end
      end
   end
endmodule : agpbr_hub_model

// file: tb/agpbr_route_ctrl_tb.sv
// self-checking bench for the bridge routing control block
`timescale 1ns/1ns

module agpbr_route_ctrl_tb;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, ctrl = 8'h00;
   logic reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0, gen = 1'b1;
   logic [3:0] iob = 4'hF, iol = 4'h0, delay = 4'h0;
   logic [11:0] mb = 12'hFFF, ml = 12'h000, pb = 12'hFFF, pl = 12'h000;
   logic host_req = 1'b0, host_io = 1'b0, ack, rv, rg, req, irq;
   logic [31:0] host_addr = 32'h00000000;
   logic [2:0] evt = 3'h0;
   logic [15:0] lfsr = 16'h91BF;
   logic [7:0] rd_q[$];
   logic route_q[$];
   int acc;
   int error_cnt = 0;
   int total_checks = 0;
   logic [15:0] io_list[16] = '{16'h03B0, 16'h03BB, 16'h03BC, 16'h03AF, 16'h03C0,
      16'h03DF, 16'h03E0, 16'hFFB0, 16'h7FDF, 16'h0FFF, 16'h1000, 16'h10FF, 16'h1100,
      16'h2FFF, 16'h3000, 16'h13C4};
   logic [31:0] mem_list[10] = '{32'h000A0000, 32'h000BFFFF, 32'h0009FFFF, 32'h000C0000,
      32'h000FFFFF, 32'h00100000, 32'h002FFFFF, 32'h00300000, 32'h010FFFFF, 32'h01100000};

   agpbr_route_ctrl dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr),
      .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
      .io_window_base_i(iob), .io_window_limit_i(iol), .memory_window_base_i(mb),
      .memory_window_limit_i(ml), .prefetch_window_base_i(pb), .prefetch_window_limit_i(pl),
      .bridge_system_error_enable_i(gen), .host_req_i(host_req), .host_req_io_i(host_io),
      .host_addr_i(host_addr), .route_valid_o(rv), .route_graphics_o(rg),
      .agp_addr_parity_err_i(evt[0]), .agp_data_parity_err_i(evt[1]),
      .other_serr_event_i(evt[2]), .serr_msg_req_o(req), .serr_msg_ack_i(ack), .irq_o(irq));

   agpbr_hub_model hub (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .msg_req_i(req),
      .msg_ack_o(ack), .delay_i(delay), .accepted_o(acc));

   initial
   begin
      forever #4 clk_i = ~clk_i;
   end

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] next_rand(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : next_rand

   function automatic logic exp_gfx(input logic io, input logic [31:0] a);
      logic vio;
      logic vmem;
      vio = (a[9:0] >= 10'h3B0 && a[9:0] <= 10'h3BB) || (a[9:0] >= 10'h3C0 && a[9:0] <= 10'h3DF);
      vmem = a >= 32'h000A0000 && a <= 32'h000BFFFF;
      if (ctrl[3] && (io ? vio : vmem))
         return 1'b1;
      if (io)
         return a[15:12] >= iob && a[15:12] <= iol && !(ctrl[2] && a[9:8] != 2'h0);
      return (a[31:20] >= mb && a[31:20] <= ml) || (a[31:20] >= pb && a[31:20] <= pl);
   endfunction : exp_gfx

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      if (a == 8'h3E)
         ctrl = d & 8'h0D;
      @(posedge clk_i);
      reg_wr <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      reg_addr <= a;
      reg_rd <= 1'b1;
      rd_q.push_back(exp);
      @(posedge clk_i);
      reg_rd <= 1'b0;
   endtask : reg_read

   task automatic send(input logic io, input logic [31:0] a);
      @(posedge clk_i);
      host_req <= 1'b1;
      host_io <= io;
      host_addr <= a;
      route_q.push_back(exp_gfx(io, a));
      @(posedge clk_i);
      host_req <= 1'b0;
   endtask : send

   task automatic pulse(input logic [2:0] e, input int n, input int exp_acc);
      @(posedge clk_i);
      evt <= e;
      repeat (n) @(posedge clk_i);
      evt <= 3'h0;
      repeat (24) @(posedge clk_i);
      check("messages accepted", acc, exp_acc);
      check("message request", req, 1'b0);
   endtask : pulse

   task automatic close_out;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out

   ////////////////////////////////////////////////////////////////////////////////
   always @(negedge clk_i)
   begin
      if (rd_seen)
         check("read data", reg_rdata, rd_q.pop_front());
      else
         check("idle read data", reg_rdata, 8'h00);
      rd_seen = reg_rd;
      if (rv)
         check("route", rg, route_q.pop_front());
   end

   initial
   begin
      repeat (5000) @(posedge clk_i);
      error_cnt++;
      close_out();
   end

   initial
   begin
      repeat (6) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      reg_read(8'h3E, 8'h00);
      reg_read(8'h80, 8'h00);
      reg_read(8'h81, 8'h00);
      reg_write(8'h3E, 8'hFF);
      reg_read(8'h3E, 8'h0D);
      reg_write(8'h55, 8'hFF);
      reg_read(8'h55, 8'h00);
      reg_write(8'h81, 8'hFF);
      reg_read(8'h81, 8'h07);
      for (int w = 0; w < 2; w++)
      begin
         @(posedge clk_i);
         iob <= w ? 4'h0 : 4'h1;
         iol <= w ? 4'h3 : 4'h2;
         mb <= w ? 12'h000 : 12'h001;
         ml <= w ? 12'h001 : 12'h002;
         pb <= w ? 12'h010 : 12'hFFF;
         pl <= w ? 12'h010 : 12'h000;
         for (int c = 0; c < 4; c++)
         begin
            reg_write(8'h3E, 8'(c << 2));
            foreach (io_list[i])
               send(1'b1, {16'h0000, io_list[i]});
            foreach (mem_list[i])
               send(1'b0, mem_list[i]);
            repeat (12)
            begin
               lfsr = next_rand(lfsr);
               send(lfsr[0], lfsr[1] ? {16'h0000, lfsr} : {7'h00, lfsr[15:7], lfsr});
            end
         end
      end
      repeat (2) @(posedge clk_i);
      check("irq", irq, 1'b1);
      reg_read(8'h80, 8'h04);
      reg_read(8'h80, 8'h00);
      check("irq", irq, 1'b0);
      reg_write(8'h81, 8'h00);
      reg_write(8'h3E, 8'h08);
      iob <= 4'hF;
      iol <= 4'h0;
      send(1'b0, 32'h000A0000);
      send(1'b1, 32'h000003B0);
      repeat (2) @(posedge clk_i);
      check("masked irq", irq, 1'b0);
      reg_read(8'h80, 8'h04);
      reg_write(8'h81, 8'h07);
      reg_write(8'h3E, 8'h00);
      pulse(3'b010, 1, 0);
      reg_read(8'h80, 8'h01);
      reg_write(8'h3E, 8'h01);
      @(posedge clk_i);
      gen <= 1'b0;
      pulse(3'b001, 1, 0);
      reg_read(8'h80, 8'h01);
      @(posedge clk_i);
      gen <= 1'b1;
      pulse(3'b001, 1, 1);
      pulse(3'b010, 1, 2);
      reg_read(8'h80, 8'h03);
      reg_write(8'h3E, 8'h00);
      delay <= 4'h5;
      pulse(3'b100, 2, 4);
      reg_read(8'h80, 8'h02);
      reg_read(8'h82, 8'h03);
      repeat (3) @(posedge clk_i);
      check("pending routes", route_q.size(), 0);
      close_out();
   end
endmodule : agpbr_route_ctrl_tb
